//--- logic/toc_channel.sv
// Timer output channel with pulse, one-shot and serial shift modes.
`timescale 1ns/1ps
// How it works
// - Shift mode runs continuously when mode is 11, one-shot off, routed stream off.
// - In continuous shift with update enable 00 the reload at period end is skipped.
// - A plain shift replaces the skipped reload, so shifting never pauses.
// - In shift mode the duty register is the shift register driving the output.
// - Trigger-started one-shot raises the second trigger in the initial phase, even at 1.
// - No second trigger when the counter hits the period again at the one-shot end.
// - Capture input resets the counter when both external trigger and reset bits set.
// - The capture reset is synchronised and acts on the next selected clock enable.
// - Output stays correct for compare values 0 and 1 under external reset.
// - Clock source picks one of eight prescaled enables; index 0 is undivided.
// - A faster enable shortens the longest period the fixed-width register reaches.
// - One-shot idles until period minus one, then pulses until duty minus one.
// - A start trigger clears the counter and begins the initial phase.
// - Both compares work in the initial phase; triggers pulse when enabled.
module toc_channel
  import toc_pkg::*;
#(
  parameter int CNT_W = TOC_CNT_W,
  parameter int CLK_N = TOC_CLK_N
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire toc_ctrl_s ctrl,
  input wire logic channel_enable,
  input wire logic signal_level,
  input wire logic [CLK_N-1:0] prescaled_clock_enable,
  // Compare and counter loads
  input wire logic [CNT_W-1:0] period_shadow,
  input wire logic [CNT_W-1:0] duty_shadow,
  input wire logic counter_write,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic trigger_chain_in,
  input wire logic capture_reset_input,
  // Trigger enables
  input wire logic first_trigger_enable,
  input wire logic second_trigger_enable,
  // Results
  output logic channel_out,
  output toc_trig_s trig,
  output toc_trig_s notify,
  output logic channel_irq,
  output logic [CNT_W-1:0] channel_counter,
  output logic [CNT_W-1:0] period_compare,
  output logic [CNT_W-1:0] duty_compare_shift,
  output toc_os_e os_state
);

  ////////////////////////////////////////////////////////////////////////////
  // Clock enable selection and capture synchronisation

  logic cap_sync;
  logic cap_prev;
  logic cap_pending;
  wire logic tick;
  wire logic cap_edge;
  wire logic ext_reset_on;
  wire logic ext_reset_now;

  assign tick = prescaled_clock_enable[ctrl.clock_source_select];

  toc_sync #(.STAGES(TOC_SYNC_STAGES)) u_cap_sync (
    .clk(clk),
    .rst(rst),
    .din(capture_reset_input),
    .dout(cap_sync)
  );

  assign cap_edge = cap_sync & ~cap_prev;
  assign ext_reset_on = ctrl.external_trigger_select & ctrl.reset_on_first_compare;
  // The event is held until the selected enable, so a slow enable never loses it.
  assign ext_reset_now = (cap_pending | (cap_edge & ext_reset_on)) & tick;

  always_ff @(posedge clk) begin
    if (rst) begin
      cap_prev <= 1'b0;
      cap_pending <= 1'b0;
    end else begin
      cap_prev <= cap_sync;
      if (tick) begin
        cap_pending <= 1'b0;
      end else if (cap_edge && ext_reset_on) begin
        cap_pending <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and compare conditions

  function automatic logic hits(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cmp);
    hits = (cmp == '0) ? (cnt == '0) : (cnt == cmp - CNT_W'(1));
  endfunction

  wire logic shift_mode;
  wire logic pwm_mode;
  wire logic shift_cont;
  wire logic skip_reload;
  wire logic os_start;
  wire logic hit_period;
  wire logic hit_duty;
  wire logic period_end;
  wire logic os_mode;
  logic [CNT_W-1:0] next_counter;
  logic next_out;
  toc_os_e next_os;

  assign shift_mode = (ctrl.mode == TOC_MODE_SHIFT);
  assign pwm_mode = (ctrl.mode == TOC_MODE_PWM);
  assign shift_cont = shift_mode & ~ctrl.one_shot_enable & ~ctrl.routed_stream_enable;
  assign skip_reload = shift_cont & (ctrl.update_enable == TOC_UPD_NONE);
  assign os_mode = pwm_mode & ctrl.one_shot_enable;
  assign os_start = os_mode & ctrl.one_shot_trigger_start & (trigger_chain_in | ext_reset_now);
  assign hit_period = hits(channel_counter, period_compare);
  assign hit_duty = hits(channel_counter, duty_compare_shift);
  assign period_end = channel_enable & tick & hit_period;

  ////////////////////////////////////////////////////////////////////////////
  // Counter, one-shot phase and output next values

  always_comb begin
    next_counter = channel_counter;
    next_os = os_state;
    next_out = channel_out;
    if (counter_write) begin
      next_counter = counter_value;
      if (os_mode) begin
        next_os = TOC_OS_INIT;
        next_out = ~signal_level;
      end
    end else if (os_start) begin
      next_counter = TOC_CNT_RST;
      next_os = TOC_OS_INIT;
      next_out = ~signal_level;
    end else if (ext_reset_now && channel_enable) begin
      next_counter = TOC_CNT_RST;
      if (pwm_mode) begin
        next_out = (duty_compare_shift != TOC_CMP_RST) ? signal_level : ~signal_level;
      end
    end else if (channel_enable && tick && !(os_mode && os_state == TOC_OS_STOP)) begin
      next_counter = hit_period ? TOC_CNT_RST : channel_counter + CNT_W'(1);
      case (os_state)
        TOC_OS_INIT: begin
          if (os_mode && hit_period) begin
            next_os = TOC_OS_PULSE;
            next_out = signal_level;
          end
        end
        TOC_OS_PULSE: begin
          if (hit_duty) begin
            next_out = ~signal_level;
          end
          if (hit_period) begin
            next_os = TOC_OS_STOP;
          end
        end
        default: begin
          if (pwm_mode && !os_mode) begin
            next_out = hit_period ? signal_level : (hit_duty ? ~signal_level : channel_out);
          end
        end
      endcase
      if (!os_mode) begin
        next_os = TOC_OS_STOP;
      end
    end
    if (shift_mode && channel_enable && tick) begin
      next_out = duty_compare_shift[0];
    end
  end

  // Second trigger fires in the initial phase and pulse, but not at the final period hit.
  wire logic trig1;
  wire logic trig0;
  assign trig0 = channel_enable & tick & hit_period & ~shift_mode;
  assign trig1 = channel_enable & tick & hit_duty & ~shift_mode &
                 ~(os_mode & os_state == TOC_OS_STOP) &
                 ~(os_mode & os_state == TOC_OS_PULSE & hit_period);

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge clk) begin
    if (rst) begin
      channel_counter <= TOC_CNT_RST;
      os_state <= TOC_OS_STOP;
      channel_out <= 1'b0;
    end else begin
      channel_counter <= next_counter;
      os_state <= next_os;
      channel_out <= next_out;
    end
  end

  // Shift register: reload at period end unless skipped, in which case it keeps shifting.
  always_ff @(posedge clk) begin
    if (rst) begin
      period_compare <= TOC_CMP_RST;
      duty_compare_shift <= TOC_CMP_RST;
    end else if (!channel_enable) begin
      period_compare <= period_shadow;
      duty_compare_shift <= duty_shadow;
    end else if (period_end && !skip_reload) begin
      period_compare <= period_shadow;
      duty_compare_shift <= duty_shadow;
    end else if (shift_mode && tick) begin
      duty_compare_shift <= {1'b0, duty_compare_shift[CNT_W-1:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trig <= '0;
      notify <= '0;
      channel_irq <= 1'b0;
    end else begin
      trig.first_compare_trigger <= trig0;
      trig.second_compare_trigger <= trig1;
      notify.first_compare_trigger <= notify.first_compare_trigger | (trig0 & first_trigger_enable);
      notify.second_compare_trigger <= notify.second_compare_trigger | (trig1 & second_trigger_enable);
      channel_irq <= (trig0 & first_trigger_enable) | (trig1 & second_trigger_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_cap_reset_gated: assert property (@(posedge clk) disable iff (rst)
    (cap_edge && ext_reset_on && !tick && channel_enable && !counter_write && !os_start)
    |=> $stable(channel_counter)) else $error("capture reset acted before the enable");
  a_cap_reset_cnt: assert property (@(posedge clk) disable iff (rst)
    (ext_reset_now && channel_enable && !counter_write && !os_start) |=> channel_counter == '0)
    else $error("capture reset did not clear counter");
  a_cnt_hold_idle: assert property (@(posedge clk) disable iff (rst)
    (!tick && !counter_write && !ext_reset_now && !os_start) |=> $stable(channel_counter))
    else $error("counter moved without enable");
  a_shift_out_bit: assert property (@(posedge clk) disable iff (rst)
    (shift_mode && channel_enable && tick) |=> channel_out == $past(duty_compare_shift[0]))
    else $error("shift output wrong");
  a_skip_keeps_shift: assert property (@(posedge clk) disable iff (rst)
    (skip_reload && period_end) |=> duty_compare_shift == ($past(duty_compare_shift) >> 1))
    else $error("reload not skipped");
  a_trig_start_clear: assert property (@(posedge clk) disable iff (rst)
    (os_start && !counter_write) |=> (channel_counter == '0 && os_state == TOC_OS_INIT))
    else $error("one-shot start failed");
  a_init_to_pulse: assert property (@(posedge clk) disable iff (rst)
    (os_mode && os_state == TOC_OS_INIT && hit_period && tick && channel_enable && !counter_write
     && !os_start && !ext_reset_now) |=> (os_state == TOC_OS_PULSE && channel_out == signal_level))
    else $error("active edge missing");
  a_no_trig_at_end: assert property (@(posedge clk) disable iff (rst)
    (os_mode && (os_state == TOC_OS_STOP || (os_state == TOC_OS_PULSE && hit_period))) |-> !trig1)
    else $error("trigger after one-shot end");
  a_init_trig_one: assert property (@(posedge clk) disable iff (rst)
    (os_mode && os_state == TOC_OS_INIT && duty_compare_shift == TOC_CNT_ONE && channel_counter == '0
     && tick && channel_enable) |-> trig1) else $error("initial trigger missing");
  a_irq_from_trig: assert property (@(posedge clk) disable iff (rst)
    (trig1 && second_trigger_enable) |=> (channel_irq && notify.second_compare_trigger))
    else $error("notify not set");
  a_cap_pend_hold: assert property (@(posedge clk) disable iff (rst)
    (cap_edge && ext_reset_on && !tick) |=> cap_pending) else $error("capture event lost");
  a_shift_step: assert property (@(posedge clk) disable iff (rst)
    (shift_mode && channel_enable && tick && !(period_end && !skip_reload))
    |=> duty_compare_shift == ($past(duty_compare_shift) >> 1)) else $error("shift step missing");
  a_reload_at_end: assert property (@(posedge clk) disable iff (rst)
    (period_end && !skip_reload) |=> (period_compare == $past(period_shadow)
     && duty_compare_shift == $past(duty_shadow))) else $error("reload missing at period end");
  a_count_step: assert property (@(posedge clk) disable iff (rst)
    (channel_enable && tick && !counter_write && !os_start && !ext_reset_now && !hit_period
     && !(os_mode && os_state == TOC_OS_STOP)) |=> channel_counter == $past(channel_counter) + CNT_W'(1))
    else $error("counter did not step");
  a_pulse_end_edge: assert property (@(posedge clk) disable iff (rst)
    (os_mode && os_state == TOC_OS_PULSE && hit_duty && tick && channel_enable && !counter_write
     && !os_start && !ext_reset_now) |=> channel_out == !$past(signal_level))
    else $error("inactive edge missing");
  a_pulse_to_stop: assert property (@(posedge clk) disable iff (rst)
    (os_mode && os_state == TOC_OS_PULSE && hit_period && tick && channel_enable && !counter_write
     && !os_start && !ext_reset_now) |=> os_state == TOC_OS_STOP)
    else $error("one-shot did not stop");
  a_os_stop_hold: assert property (@(posedge clk) disable iff (rst)
    (os_mode && os_state == TOC_OS_STOP && !counter_write && !os_start && !ext_reset_now)
    |=> $stable(channel_counter)) else $error("counter moved after one-shot end");
  a_ext_out_level: assert property (@(posedge clk) disable iff (rst)
    (ext_reset_now && channel_enable && pwm_mode && !counter_write && !os_start
     && duty_compare_shift != TOC_CMP_RST) |=> channel_out == $past(signal_level))
    else $error("output wrong after capture reset");
  a_notify_sticky: assert property (@(posedge clk) disable iff (rst)
    notify.second_compare_trigger |=> notify.second_compare_trigger) else $error("notify bit dropped");

  c_shift_skip: cover property (@(posedge clk) skip_reload && period_end);
  c_os_pulse: cover property (@(posedge clk) os_state == TOC_OS_INIT ##[1:100] os_state == TOC_OS_PULSE);
  c_cap_reset: cover property (@(posedge clk) ext_reset_now && channel_enable);
  c_cap_pending: cover property (@(posedge clk) cap_pending && !tick);
  c_init_trig: cover property (@(posedge clk) os_state == TOC_OS_INIT && trig1);

endmodule

//--- inc/toc_pkg.sv
// Package with modes, widths, reset values and carriers for the timer output channel.
package toc_pkg;

  localparam int TOC_CNT_W = 24;
  localparam int TOC_CLK_N = 8;
  localparam int TOC_SRC_W = 3;
  localparam logic [TOC_CNT_W-1:0] TOC_CNT_RST = 24'h000000;
  localparam logic [TOC_CNT_W-1:0] TOC_CMP_RST = 24'h000000;
  localparam logic [TOC_CNT_W-1:0] TOC_CNT_ONE = 24'h000001;
  localparam logic [TOC_CNT_W-1:0] TOC_SHIFT_MAX = 24'h000017;
  localparam logic [1:0] TOC_UPD_NONE = 2'h0;
  localparam int TOC_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    TOC_MODE_IDLE = 2'b00,
    TOC_MODE_IMM = 2'b01,
    TOC_MODE_PWM = 2'b10,
    TOC_MODE_SHIFT = 2'b11
  } toc_mode_e;

  typedef enum logic [1:0] {
    TOC_OS_STOP = 2'b00,
    TOC_OS_INIT = 2'b01,
    TOC_OS_PULSE = 2'b10
  } toc_os_e;

  typedef struct packed {
    toc_mode_e mode;
    logic one_shot_enable;
    logic one_shot_trigger_start;
    logic routed_stream_enable;
    logic external_trigger_select;
    logic reset_on_first_compare;
    logic [1:0] update_enable;
    logic [TOC_SRC_W-1:0] clock_source_select;
  } toc_ctrl_s;

  typedef struct packed {
    logic first_compare_trigger;
    logic second_compare_trigger;
  } toc_trig_s;

endpackage

//--- logic/toc_sync.sv
// Two-stage synchroniser for a level that arrives from outside the clock domain.
`timescale 1ns/1ps
module toc_sync
  import toc_pkg::*;
#(
  parameter int STAGES = TOC_SYNC_STAGES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  input wire logic din,
  output logic dout
);

  logic [STAGES-1:0] stage;

  // Only the last stage is read outside; the first is seen by the second alone.
  always_ff @(posedge clk) begin
    if (rst) begin
      stage <= '0;
    end else begin
      stage <= {stage[STAGES-2:0], din};
    end
  end

  assign dout = stage[STAGES-1];

endmodule

//--- bench/toc_clock_trigger_model.sv
// Partner model: prescaled clock enables and the capture pulse source.
`timescale 1ns/1ps
module toc_clock_trigger_model
  import toc_pkg::*;
#(
  parameter int HOLD = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the bench
  input wire logic capture_req,
  // Towards the channel
  output logic [TOC_CLK_N-1:0] prescaled_clock_enable,
  output logic capture_reset_input
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] div_cnt;
  logic [3:0] hold_cnt;
  // Index 0 fires every cycle; index i fires once in 2**i cycles.
  always_comb begin
    for (int i = 0; i < TOC_CLK_N; i++) begin
      prescaled_clock_enable[i] = (div_cnt & ((8'h01 << i) - 8'h01)) == ((8'h01 << i) - 8'h01);
    end
  end
  // The capture level is held a few cycles and then drops to its idle low.
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt <= 8'h00;
      hold_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      if (capture_req) begin
        hold_cnt <= 4'(HOLD);
      end else if (hold_cnt != 4'h0) begin
        hold_cnt <= hold_cnt - 4'h1;
      end
    end
  end
  assign capture_reset_input = (hold_cnt != 4'h0);
endmodule

//--- bench/test_timer_output_channel_shift_oneshot.sv
// Self-checking bench for the timer output channel.
`timescale 1ns/1ps
module test_timer_output_channel_shift_oneshot;
  import toc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  toc_ctrl_s ctrl = '0;
  logic ch_en = 1'b0;
  logic sig_lvl = 1'b1;
  logic trig_in = 1'b0;
  logic cap_req = 1'b0;
  logic cnt_wr = 1'b0;
  // The first trigger stays disabled, so its notify bit must never set.
  logic en0 = 1'b0;
  logic en1 = 1'b1;
  logic [23:0] per_sh = 24'h000000;
  logic [23:0] duty_sh = 24'h000000;
  logic [7:0] pce;
  logic cap_in;
  logic ch_out;
  logic irq;
  toc_trig_s trig;
  toc_trig_s notify;
  logic [23:0] cnt;
  logic [23:0] pcmp;
  logic [23:0] dcs;
  toc_os_e os;
  int fails = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #12.5 clk = ~clk;
  toc_clock_trigger_model part_u (.clk(clk), .rst(rst), .capture_req(cap_req),
    .prescaled_clock_enable(pce), .capture_reset_input(cap_in));
  toc_channel dut_u (.clk(clk), .rst(rst), .ctrl(ctrl), .channel_enable(ch_en), .signal_level(sig_lvl),
    .prescaled_clock_enable(pce), .period_shadow(per_sh), .duty_shadow(duty_sh), .counter_write(cnt_wr),
    .counter_value(24'h000000), .trigger_chain_in(trig_in), .capture_reset_input(cap_in),
    .first_trigger_enable(en0), .second_trigger_enable(en1), .channel_out(ch_out), .trig(trig),
    .notify(notify), .channel_irq(irq), .channel_counter(cnt), .period_compare(pcmp),
    .duty_compare_shift(dcs), .os_state(os));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Shift order is LSB first, so bit k leaves after k enables.
  function automatic logic shift_bit(input logic [23:0] p, input int k);
    return p[k];
  endfunction
  // Compare values and a zero count load while the channel is held off, then it runs.
  task automatic setup(input toc_mode_e m, input logic o, input logic e, input logic r, input logic [2:0] s,
                       input logic [23:0] per, input logic [23:0] duty);
    @(posedge clk);
    ch_en <= 1'b0;
    cnt_wr <= 1'b1;
    ctrl <= '{m, o, o, 1'b0, e, r, TOC_UPD_NONE, s};
    per_sh <= per;
    duty_sh <= duty;
    @(posedge clk);
    cnt_wr <= 1'b0;
    @(posedge clk);
    ch_en <= 1'b1;
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int t;
    int c0;
    int hit;
    int a;
    int b;
    int act;
    logic [2:0] src;
    logic [23:0] pat;
    void'($urandom(32'hBE03));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(cnt, 0);
    check(dcs | pcmp, 0);
    check({ch_out, os, trig, notify, irq}, 0);
    // Counter advances exactly on the selected enable.
    for (int r = 0; r < 4; r++) begin
      src = 3'($urandom_range(7, 0));
      sig_lvl <= 1'($urandom);
      setup(TOC_MODE_PWM, 1'b0, 1'b0, 1'b0, src, 24'hFFFFFF, 24'hFFFFFF);
      c0 = int'(cnt);
      t = 0;
      repeat (300) begin
        t += int'(pce[src]);
        @(negedge clk);
      end
      check(cnt, c0 + t);
    end
    // Continuous shift runs through the period end without a gap.
    for (int r = 0; r < 3; r++) begin
      pat = 24'($urandom);
      setup(TOC_MODE_SHIFT, 1'b0, 1'b0, 1'b0, 3'h0, 24'($urandom_range(23, 2)), pat);
      for (int k = 0; k < 24; k++) begin
        check(dcs[0], shift_bit(pat, k));
        if (k > 0) check(ch_out, shift_bit(pat, k - 1));
        @(negedge clk);
      end
    end
    // Trigger-started one-shot, second compare at 1 and at 3.
    for (int d = 1; d <= 3; d += 2) begin
      setup(TOC_MODE_PWM, 1'b1, 1'b0, 1'b0, 3'h0, 24'h000006, 24'(d));
      @(posedge clk);
      trig_in <= 1'b1;
      @(posedge clk);
      trig_in <= 1'b0;
      @(negedge clk);
      check({os, cnt}, {TOC_OS_INIT, 24'h000000});
      a = 0;
      b = 0;
      act = 0;
      hit = 0;
      for (int n = 0; n < 100 && hit == 0; n++) begin
        check(irq, trig.second_compare_trigger);
        if (os === TOC_OS_INIT && trig.second_compare_trigger === 1'b1) a++;
        if (os === TOC_OS_PULSE && ch_out === sig_lvl) act = 1;
        if (os === TOC_OS_STOP) hit = 1;
        else @(negedge clk);
      end
      if (hit == 0) begin
        fails++;
        tally_and_finish();
      end
      repeat (3) begin
        b += int'(trig.second_compare_trigger === 1'b1);
        @(negedge clk);
      end
      check(a != 0, 1);
      check(b, 0);
      check(notify.second_compare_trigger, 1);
      if (d == 3) check(act, 1);
    end
    // Capture reset: refused without the reset bit, else lands on a tick.
    for (int r = 0; r < 2; r++) begin
      setup(TOC_MODE_PWM, 1'b0, 1'b1, 1'(r), 3'h2, 24'hFFFFFF, 24'h000001);
      repeat (20) @(posedge clk);
      cap_req <= 1'b1;
      @(posedge clk);
      cap_req <= 1'b0;
      @(negedge clk);
      hit = 0;
      c0 = 0;
      for (int n = 0; n < 60 && hit == 0; n++) begin
        t = int'(pce[2]);
        @(negedge clk);
        if (cnt === 24'h000000) begin
          hit = 1;
          c0 = n;
        end
      end
      check(hit, r);
      if (r == 1) check(t, 1);
      if (r == 1) check(c0 >= 2, 1);
      if (r == 1) check(ch_out, sig_lvl);
    end
    check(notify.first_compare_trigger, 0);
    tally_and_finish();
  end
endmodule
